//--- hdl/async_serial_control_regs.sv
// Behaviour
// - Clock source codes 0..3: internal, low-freq, high-freq, external input.
// - Internal/high-freq divide 1,2,4,8; other sources ignore the divide code, undivided.
// - Debug-run 1 keeps operating clock in debug mode; 0 withholds it.
// - Clock, mode and baud registers change only while disabled.
// - Carrier enable modulates output during high or low data periods.
// - Baud divider select: 1 gives 1/4, 0 gives 1/16 sampling.
// - Receive and transmit invert bits invert input and output lines.
// - Pull-up enable requests a pull-up on the input pad.
// - Output mode 1 is open-drain, 0 is push-pull.
// - Infrared mode enables the return-to-zero modulator path.
// - Data length 1 gives 8 bits, 0 gives 7 bits.
// - Parity enable adds parity; type 1 odd, 0 even.
// - Stop length 1 gives two stop bits, 0 gives one.
// - Baud register holds fine adjust 11..8 and rate count 7..0.
// - Soft reset clears flags and receive FIFO, not the registers; reads 1 then self-clears.
// - Module enable supplies operating clock; clearing it stops it.
// - Transmit write is taken whatever the empty flag; write clears it unless the shifter loads in the same cycle; resets to 1.
// - Receive port pops two-byte FIFO oldest first; flags drain.
// - Busy bits show frame reception and transmission in progress.
// - End and overrun clear on write 1; errors also on errored read.
// - Interrupt enable register holds seven enables at bits 6..0.
// - Carrier period field sets carrier frequency.
// - Carrier frequency is operating clock over twice (period plus one).
// - Interrupt request only while an enabled flag is set.
// - One-full sets on first byte, two-full on second unread byte.
`timescale 1ns/100ps
`default_nettype none
`include "serial_regs_cfg.svh"
module async_serial_control_regs (
    input  wire logic        clk_i,               // 250 MHz clock
    input  wire logic        rst_b_i,             // Async reset, low
    input  wire logic        hsel_i,              // AHB select
    input  wire logic [31:0] haddr_i,             // AHB address
    input  wire logic [1:0]  htrans_i,            // AHB transfer type
    input  wire logic        hwrite_i,            // AHB write
    input  wire logic [31:0] hwdata_i,            // AHB write data
    input  wire logic        hready_i,            // AHB ready in
    output var  logic [31:0] hrdata_o,            // AHB read data
    output var  logic        hreadyout_o,         // AHB ready out
    output var  logic        hresp_o,             // AHB response
    input  wire logic [3:0]  src_tick_i,          // Source clock enables
    input  wire logic        debug_mode_i,        // Processor in debug
    input  wire logic        tx_line_i,           // Shifter serial out
    input  wire logic        tx_load_i,           // Shifter took byte
    input  wire logic        tx_end_i,            // Stop bit sent
    input  wire logic        tx_busy_i,           // Sending frame
    input  wire logic        rx_busy_i,           // Receiving frame
    input  wire logic        rx_valid_i,          // Received byte pulse
    input  wire logic [7:0]  rx_data_i,           // Received byte
    input  wire logic        rx_frame_err_i,      // Stop bit was 0
    input  wire logic        rx_parity_err_i,     // Parity mismatch
    input  wire logic        serial_in_pin_i,     // Serial input pad
    output var  logic        serial_out_pin_o,    // Serial output pad
    output var  logic        serial_out_pin_oe_o, // Output pad enable
    output var  logic        pullup_enable_o,     // Input pad pull-up
    output var  logic        op_tick_o,           // Operating clock enable
    output var  logic        sample_tick_o,       // Sampling clock enable
    output var  logic        rx_line_o,           // Conditioned input
    output var  logic [7:0]  tx_data_o,           // Byte to send
    output var  logic        tx_data_valid_o,     // Byte waiting
    output var  logic        shifter_reset_o,     // Shifter soft reset
    output var  logic        data_length_o,       // 1: eight bits
    output var  logic        parity_enable_o,     // Parity on
    output var  logic        parity_type_o,       // 1: odd
    output var  logic        stop_length_o,       // 1: two stop bits
    output var  logic        infrared_mode_o,     // Infrared path on
    output var  logic [3:0]  fine_adjust_o,       // Fine adjust
    output var  logic [7:0]  rate_count_o,        // Rate count
    output var  logic        irq_o                // Interrupt request
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction : hit

    function automatic logic [2:0] div_max(input serial_regs_pkg::clk_src_t s,
                                           input logic [1:0] d);
        if (s == serial_regs_pkg::SRC_INTERNAL || s == serial_regs_pkg::SRC_HIGH_FREQ)
            return 3'((4'h1 << d) - 4'h1);
        return 3'h0;
    endfunction : div_max

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    logic        pend;
    logic        pend_wr;
    logic [7:0]  pend_addr;
    logic        accept;
    logic        wr;
    logic        rd;
    logic [31:0] rd_mux;

    assign accept  = hsel_i && htrans_i[1] && hready_i;
    assign wr      = pend && pend_wr;
    assign rd      = pend && !pend_wr;
    assign hresp_o = 1'b0;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pend        <= 1'b0;
            pend_wr     <= 1'b0;
            pend_addr   <= 8'h00;
            hreadyout_o <= 1'b1;
        end else begin
            pend        <= accept;
            hreadyout_o <= !accept;
            if (accept) begin
                pend_wr   <= hwrite_i;
                pend_addr <= haddr_i[7:0];
            end
        end
    end

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    logic [15:0] clk_reg;
    logic [15:0] mode_reg;
    logic [15:0] baud_reg;
    logic [6:0]  ien_reg;
    logic [7:0]  car_reg;
    logic        enable;
    logic        srst;
    logic [1:0]  srst_cnt;
    logic        cfg_open;

    assign cfg_open = !enable;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            clk_reg  <= `REG_RST;
            mode_reg <= `REG_RST;
            baud_reg <= `REG_RST;
            ien_reg  <= 7'h00;
            car_reg  <= 8'h00;
        end else if (wr) begin
            if (hit(pend_addr, `OFS_CLK) && cfg_open)
                clk_reg <= hwdata_i[15:0] & `CLK_MASK;
            if (hit(pend_addr, `OFS_MODE) && cfg_open)
                mode_reg <= hwdata_i[15:0] & `MODE_MASK;
            if (hit(pend_addr, `OFS_BAUD) && cfg_open)
                baud_reg <= hwdata_i[15:0] & `BAUD_MASK;
            if (hit(pend_addr, `OFS_IEN))
                ien_reg <= hwdata_i[6:0] & `IEN_MASK;
            if (hit(pend_addr, `OFS_CAR))
                car_reg <= hwdata_i[7:0];
        end
    end

    assign pullup_enable_o = mode_reg[`MODE_PULLUP];
    assign data_length_o   = mode_reg[`MODE_LEN8];
    assign parity_enable_o = mode_reg[`MODE_PAR_EN];
    assign parity_type_o   = mode_reg[`MODE_PAR_ODD];
    assign stop_length_o   = mode_reg[`MODE_STOP2];
    assign infrared_mode_o = mode_reg[`MODE_IR];
    assign fine_adjust_o   = baud_reg[11:8];
    assign rate_count_o    = baud_reg[7:0];

    // Enable stays writable; soft reset runs a fixed short sequence
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            enable          <= 1'b0;
            srst            <= 1'b0;
            srst_cnt        <= 2'h0;
            shifter_reset_o <= 1'b0;
        end else begin
            shifter_reset_o <= srst;
            if (wr && hit(pend_addr, `OFS_CTL))
                enable <= hwdata_i[`CTL_EN];
            // Countdown must not stall when the control word is written again meanwhile
            if (wr && hit(pend_addr, `OFS_CTL) && hwdata_i[`CTL_SRST] && !srst) begin
                srst     <= 1'b1;
                srst_cnt <= `SRST_LEN;
            end else if (srst) begin
                srst_cnt <= 2'(srst_cnt - 2'h1);
                if (srst_cnt == 2'h1)
                    srst <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Operating and sampling clock enables
    // ----------------------------------------
    logic       op_run;
    logic       src_sel;
    logic [2:0] div_cnt;
    logic [2:0] div_lim;
    logic [3:0] samp_cnt;
    logic [3:0] samp_lim;

    assign op_run   = enable && (!debug_mode_i || clk_reg[`CLK_DEBUG_RUN]);
    assign src_sel  = src_tick_i[clk_reg[1:0]];
    assign div_lim  = div_max(serial_regs_pkg::clk_src_t'(clk_reg[1:0]), clk_reg[5:4]);
    assign samp_lim = mode_reg[`MODE_BAUD_DIV] ? `SAMP_FAST : `SAMP_SLOW;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_cnt   <= 3'h0;
            op_tick_o <= 1'b0;
        end else begin
            op_tick_o <= op_run && src_sel && div_cnt >= div_lim;
            if (!op_run)
                div_cnt <= 3'h0;
            else if (src_sel)
                div_cnt <= (div_cnt >= div_lim) ? 3'h0 : 3'(div_cnt + 3'h1);
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            samp_cnt      <= 4'h0;
            sample_tick_o <= 1'b0;
        end else begin
            sample_tick_o <= op_tick_o && samp_cnt >= samp_lim;
            if (!enable)
                samp_cnt <= 4'h0;
            else if (op_tick_o)
                samp_cnt <= (samp_cnt >= samp_lim) ? 4'h0 : 4'(samp_cnt + 4'h1);
        end
    end

    // ----------------------------------------
    // Receive buffer and flags
    // ----------------------------------------
    rx_fifo_if fif ();

    rx_fifo2 u_fifo (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .fif     (fif)
    );

    logic       tx_full;
    logic       tend;
    logic       fe;
    logic       pe;
    logic       ovr;
    logic [6:0] flag_vec;
    logic [6:0] w1c;
    logic       fe_set;
    logic       pe_set;
    logic       two_full;
    logic       irq_cause;

    assign two_full      = fif.count == 2'h2;
    assign fif.clear     = srst;
    assign fif.push      = rx_valid_i && !two_full && !srst;
    assign fif.push_word = {rx_parity_err_i, rx_frame_err_i, rx_data_i};
    assign fif.pop       = rd && hit(pend_addr, `OFS_RXD) && fif.count != 2'h0;
    assign flag_vec      = {tend, fe, pe, ovr, two_full, fif.count != 2'h0, !tx_full};
    assign w1c           = (wr && hit(pend_addr, `OFS_FLAG)) ? hwdata_i[6:0] & `W1C_MASK
                                                           : 7'h00;
    // Error flags rise only when the errored byte reaches the head
    assign fe_set = (fif.push && fif.count == 2'h0 && rx_frame_err_i)
                 || (fif.pop && two_full && fif.second[`WORD_FE]);
    assign pe_set = (fif.push && fif.count == 2'h0 && rx_parity_err_i)
                 || (fif.pop && two_full && fif.second[`WORD_PE]);
    assign tx_data_valid_o = tx_full;
    assign irq_cause       = |(flag_vec & ien_reg);

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_full <= 1'b0;
            tend    <= 1'b0;
            fe      <= 1'b0;
            pe      <= 1'b0;
            ovr     <= 1'b0;
        end else if (srst) begin
            tx_full <= 1'b0;
            tend    <= 1'b0;
            fe      <= 1'b0;
            pe      <= 1'b0;
            ovr     <= 1'b0;
        end else begin
            if (tx_load_i)
                tx_full <= 1'b0;
            else if (wr && hit(pend_addr, `OFS_TXD))
                tx_full <= 1'b1;
            if (tx_end_i && !tx_full)
                tend <= 1'b1;
            else if (w1c[6])
                tend <= 1'b0;
            if (fe_set)
                fe <= 1'b1;
            else if (w1c[5] || (fif.pop && fif.head[`WORD_FE]))
                fe <= 1'b0;
            if (pe_set)
                pe <= 1'b1;
            else if (w1c[4] || (fif.pop && fif.head[`WORD_PE]))
                pe <= 1'b0;
            if (rx_valid_i && two_full)
                ovr <= 1'b1;
            else if (w1c[3])
                ovr <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_data_o <= 8'h00;
            irq_o     <= 1'b0;
        end else begin
            irq_o <= irq_cause;
            if (wr && hit(pend_addr, `OFS_TXD))
                tx_data_o <= hwdata_i[7:0];
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (pend_addr)
            `OFS_CLK:  rd_mux[15:0] = clk_reg;
            `OFS_MODE: rd_mux[15:0] = mode_reg;
            `OFS_BAUD: rd_mux[15:0] = baud_reg;
            `OFS_CTL:  rd_mux[1:0]  = {srst, enable};
            `OFS_TXD:  rd_mux[7:0]  = tx_data_o;
            `OFS_RXD:  rd_mux[7:0]  = fif.head[7:0];
            `OFS_FLAG: rd_mux[9:0]  = {rx_busy_i, tx_busy_i, 1'b0, flag_vec};
            `OFS_IEN:  rd_mux[6:0]  = ien_reg;
            `OFS_CAR:  rd_mux[7:0]  = car_reg;
            default:   rd_mux       = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i)
            hrdata_o <= 32'h0000_0000;
        else
            hrdata_o <= rd ? rd_mux : 32'h0000_0000;
    end

    // ----------------------------------------
    // Line conditioning
    // ----------------------------------------
    logic rx_q1;
    logic rx_q2;
    logic rx_q3;
    logic wave;
    logic tx_lvl;

    carrier_gen #(.W(8)) u_car (
        .clk_i    (clk_i),
        .rst_b_i  (rst_b_i),
        .tick_i   (op_tick_o),
        .run_i    (mode_reg[`MODE_CAR_EN]),
        .period_i (car_reg),
        .wave_o   (wave)
    );

    always_comb begin
        tx_lvl = tx_line_i;
        if (mode_reg[`MODE_CAR_EN] && tx_line_i == mode_reg[`MODE_CAR_SEL])
            tx_lvl = wave;
        tx_lvl = tx_lvl ^ mode_reg[`MODE_TX_INV];
    end

    // Input held only once two later stages agree, rejecting a one-cycle glitch
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_q1               <= 1'b1;
            rx_q2               <= 1'b1;
            rx_q3               <= 1'b1;
            rx_line_o           <= 1'b1;
            serial_out_pin_o    <= 1'b1;
            serial_out_pin_oe_o <= 1'b1;
        end else begin
            rx_q1 <= serial_in_pin_i;
            rx_q2 <= rx_q1;
            rx_q3 <= rx_q2;
            if (rx_q2 == rx_q3)
                rx_line_o <= rx_q3 ^ mode_reg[`MODE_RX_INV];
            if (mode_reg[`MODE_OPEN_DRAIN]) begin
                serial_out_pin_o    <= 1'b0;
                serial_out_pin_oe_o <= !tx_lvl;
            end else begin
                serial_out_pin_o    <= tx_lvl;
                serial_out_pin_oe_o <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    AST_LOCK: assert property (wr && hit(pend_addr, `OFS_MODE) && enable
        |=> $stable(mode_reg)) else $error("mode changed while enabled");
    AST_TBE_CLR: assert property (wr && hit(pend_addr, `OFS_TXD) && !tx_load_i && !srst
        |=> !flag_vec[0]) else $error("tx empty not cleared");
    AST_SRST: assert property (wr && hit(pend_addr, `OFS_CTL) && hwdata_i[`CTL_SRST] && !srst
        |=> srst[*2] ##1 !srst) else $error("soft reset length wrong");
    AST_SRST_FLAGS: assert property (srst |=> flag_vec[6:3] == 4'h0 && flag_vec[0])
        else $error("flags not reset");
    AST_IRQ: assert property (irq_o == $past(irq_cause))
        else $error("irq mismatch");
    AST_OVR: assert property (rx_valid_i && two_full && !srst |=> ovr)
        else $error("overrun not flagged");
    AST_TEND_W1C: assert property (w1c[6] && !(tx_end_i && !tx_full) && !srst |=> !tend)
        else $error("end flag not cleared");
    AST_RB1: assert property (fif.push && fif.count == 2'h0 |=> flag_vec[1])
        else $error("one full not set");
    AST_OPEN: assert property (mode_reg[`MODE_OPEN_DRAIN] && $stable(mode_reg)
        |=> !(serial_out_pin_oe_o && serial_out_pin_o)) else $error("open drain drove high");
    AST_DBG: assert property (debug_mode_i && !clk_reg[`CLK_DEBUG_RUN] |=> !op_tick_o)
        else $error("clock ran in debug");
    AST_BUS: assert property (accept |=> !hreadyout_o ##1 hreadyout_o)
        else $error("bus answer timing");

    COV_TWO_READ: cover property (fif.pop && two_full);
    COV_SRST: cover property (srst ##1 !srst);
    COV_IRQ: cover property (!irq_o ##1 irq_o);
    COV_FE: cover property (fe_set);
endmodule : async_serial_control_regs
`default_nettype wire

//--- hdl/serial_regs_cfg.svh
`ifndef SERIAL_REGS_CFG_SVH
`define SERIAL_REGS_CFG_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CLK   8'h00
`define OFS_MODE  8'h04
`define OFS_BAUD  8'h08
`define OFS_CTL   8'h0C
`define OFS_TXD   8'h10
`define OFS_RXD   8'h14
`define OFS_FLAG  8'h18
`define OFS_IEN   8'h1C
`define OFS_CAR   8'h20
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CLK_DEBUG_RUN   8
`define MODE_CAR_SEL    12
`define MODE_CAR_EN     11
`define MODE_BAUD_DIV   10
`define MODE_RX_INV     9
`define MODE_TX_INV     8
`define MODE_PULLUP     6
`define MODE_OPEN_DRAIN 5
`define MODE_IR         4
`define MODE_LEN8       3
`define MODE_PAR_EN     2
`define MODE_PAR_ODD    1
`define MODE_STOP2      0
`define CTL_SRST    1
`define CTL_EN      0
`define WORD_FE     8
`define WORD_PE     9
// ----------------------------------------
// Masks, reset values and counts
// ----------------------------------------
`define CLK_MASK    16'h0133
`define MODE_MASK   16'h1F7F
`define BAUD_MASK   16'h0FFF
`define IEN_MASK    7'h7F
`define W1C_MASK    7'h78
`define REG_RST     16'h0000
`define SAMP_FAST   4'h3
`define SAMP_SLOW   4'hF
`define SRST_LEN    2'h2
`endif

//--- hdl/serial_regs_pkg.sv
`default_nettype none
package serial_regs_pkg;
    typedef enum logic [1:0] {
        SRC_INTERNAL,
        SRC_LOW_FREQ,
        SRC_HIGH_FREQ,
        SRC_EXTERNAL
    } clk_src_t;
endpackage : serial_regs_pkg
`default_nettype wire

//--- hdl/rx_fifo_if.sv
`timescale 1ns/100ps
`default_nettype none
interface rx_fifo_if;
    logic       push;
    logic [9:0] push_word;
    logic       pop;
    logic       clear;
    logic [9:0] head;
    logic [9:0] second;
    logic [1:0] count;
    modport owner (output push, push_word, pop, clear, input head, second, count);
    modport store (input push, push_word, pop, clear, output head, second, count);
endinterface : rx_fifo_if
`default_nettype wire

//--- hdl/rx_fifo2.sv
`timescale 1ns/100ps
`default_nettype none
module rx_fifo2 (
    input  wire logic   clk_i,   // Clock
    input  wire logic   rst_b_i, // Async reset
    rx_fifo_if.store    fif      // Store side
);
    logic [9:0] mem [0:1];
    logic [1:0] count;

    assign fif.head   = mem[0];
    assign fif.second = mem[1];
    assign fif.count  = count;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count <= 2'h0;
        end else if (fif.clear) begin
            count <= 2'h0;
        end else begin
            count <= 2'(count + {1'b0, fif.push} - {1'b0, fif.pop});
        end
    end

    // Owner never pushes when full nor pops when empty
    always_ff @(posedge clk_i) begin
        if (fif.pop) begin
            mem[0] <= mem[1];
        end
        if (fif.push) begin
            mem[1'(count - {1'b0, fif.pop})] <= fif.push_word;
        end
    end
endmodule : rx_fifo2
`default_nettype wire

//--- hdl/carrier_gen.sv
`timescale 1ns/100ps
`default_nettype none
module carrier_gen #(
    parameter int W = 8
) (
    input  wire logic         clk_i,    // Clock
    input  wire logic         rst_b_i,  // Async reset
    input  wire logic         tick_i,   // Operating clock enable
    input  wire logic         run_i,    // Carrier active
    input  wire logic [W-1:0] period_i, // Half period minus one
    output var  logic         wave_o    // Carrier wave
);
    logic [W-1:0] cnt;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt    <= '0;
            wave_o <= 1'b0;
        end else if (!run_i) begin
            cnt    <= '0;
            wave_o <= 1'b0;
        end else if (tick_i) begin
            if (cnt == period_i) begin
                cnt    <= '0;
                wave_o <= !wave_o;
            end else begin
                cnt <= W'(cnt + 1'b1);
            end
        end
    end
endmodule : carrier_gen
`default_nettype wire

//--- verification/far_side.sv
`timescale 1ns/100ps
`default_nettype none
module far_side (
    input  wire logic       clk_i,   // Clock
    input  wire logic       hold_i,  // Stall
    input  wire logic       valid_i, // Byte waits
    output var  logic       load_o,  // Took byte
    output var  logic       end_o,   // Stop sent
    output var  logic       rxv_o,   // Byte in
    output var  logic       fe_o,    // Bad stop
    output var  logic [7:0] rxd_o    // Data in
);
    initial begin
        {load_o, end_o, rxv_o, fe_o, rxd_o} = 12'h000;
    end
    // Stall stands for a shifter still busy
    always @(posedge clk_i) begin
        load_o <= valid_i & ~load_o & ~hold_i;
        end_o  <= load_o;
    end
    task automatic send(input logic [7:0] b, input logic f);
        @(posedge clk_i);
        {rxv_o, fe_o, rxd_o} <= {1'b1, f, b};
        @(posedge clk_i);
        {rxv_o, fe_o, rxd_o} <= {1'b0, ~f, ~b};
    endtask : send
endmodule : far_side
`default_nettype wire

//--- verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "serial_regs_cfg.svh"
module testbench;
    logic        clk_i   = 1'b0;
    logic        rst_b_i = 1'b0;
    logic        hsel    = 1'b0;
    logic        hwrite  = 1'b0;
    logic        hold    = 1'b1;
    logic [1:0]  htrans  = 2'h0;
    logic [31:0] haddr   = 32'h0;
    logic [31:0] hwdata  = 32'h0;
    logic [31:0] hrdata;
    logic        hrdy, ld, te, rxv, fe, irq, txv, dl;
    logic        opt, pu, pen, pty, stl, ir, rxl;
    logic        dbg     = 1'b0;
    logic [7:0]  rxd, txd;
    int          n_fail  = 0;
    int          n_tests = 0;
    int          cyc     = 0;
    always #2 clk_i = ~clk_i;
    async_serial_control_regs dut (
        .clk_i, .rst_b_i, .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
        .hreadyout_o(hrdy), .hresp_o(), .src_tick_i(4'hF), .debug_mode_i(dbg),
        .tx_line_i(1'b1), .tx_load_i(ld), .tx_end_i(te), .tx_busy_i(ld),
        .rx_busy_i(rxv), .rx_valid_i(rxv), .rx_data_i(rxd), .rx_frame_err_i(fe),
        .rx_parity_err_i(1'b0), .serial_in_pin_i(1'b1), .serial_out_pin_o(),
        .serial_out_pin_oe_o(), .pullup_enable_o(pu), .op_tick_o(opt), .sample_tick_o(),
        .rx_line_o(rxl), .tx_data_o(txd), .tx_data_valid_o(txv), .shifter_reset_o(),
        .data_length_o(dl), .parity_enable_o(pen), .parity_type_o(pty), .stop_length_o(stl),
        .infrared_mode_o(ir), .fine_adjust_o(), .rate_count_o(), .irq_o(irq));
    far_side p (.clk_i, .hold_i(hold), .valid_i(txv), .load_o(ld), .end_o(te),
                .rxv_o(rxv), .fe_o(fe), .rxd_o(rxd));
    task automatic final_report;
        $display("tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            n_fail++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    // One AHB single transfer; waits on ready, no fixed latency assumed
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        hsel   <= 1'b1;
        do @(posedge clk_i); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_i); while (hrdy !== 1'b1);
        q = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask : rd
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            final_report();
        end
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        rd(`OFS_FLAG, 32'h1);
        rd(`OFS_IEN, 32'h0);
        wr(`OFS_MODE, 32'hFFEF);
        rd(`OFS_MODE, 32'h1F6F);
        chk({31'h0, dl}, 32'h1);
        chk({25'h0, dl, pen, pty, stl, pu, ir, rxl}, 32'h7C);
        wr(`OFS_BAUD, 32'hF3AB);
        rd(`OFS_BAUD, 32'h3AB);
        wr(`OFS_CTL, 32'h1);
        wr(`OFS_MODE, 32'h0);
        rd(`OFS_MODE, 32'h1F6F);
        dbg <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk({31'h0, opt}, 32'h0);
        dbg <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk({31'h0, opt}, 32'h1);
        $display("config test done");
        wr(`OFS_TXD, 32'h5A);
        rd(`OFS_FLAG, 32'h0);
        chk({24'h0, txd}, 32'h5A);
        hold <= 1'b0;
        repeat (4) @(posedge clk_i);
        rd(`OFS_FLAG, 32'h41);
        wr(`OFS_FLAG, 32'h40);
        rd(`OFS_FLAG, 32'h1);
        $display("transmit test done");
        wr(`OFS_IEN, 32'h02);
        p.send(8'h11, 1'b1);
        p.send(8'h22, 1'b0);
        p.send(8'h33, 1'b0);
        rd(`OFS_FLAG, 32'h2F);
        chk({31'h0, irq}, 32'h1);
        rd(`OFS_RXD, 32'h11);
        rd(`OFS_FLAG, 32'h0B);
        rd(`OFS_RXD, 32'h22);
        wr(`OFS_FLAG, 32'h08);
        rd(`OFS_FLAG, 32'h01);
        chk({31'h0, irq}, 32'h0);
        $display("receive test done");
        hold <= 1'b1;
        wr(`OFS_TXD, 32'h77);
        wr(`OFS_CTL, 32'h3);
        repeat (4) @(posedge clk_i);
        rd(`OFS_FLAG, 32'h1);
        rd(`OFS_CTL, 32'h1);
        rd(`OFS_MODE, 32'h1F6F);
        $display("soft reset test done");
        final_report();
    end
endmodule : testbench
`default_nettype wire
